// File: logic/smx_map.svh
// register offsets, field positions, reset values and pin timing
// assumes the 8-bit register port of smx_top
// How it works
// RULE1 - output is the selected carrier gated by the modulator state
// RULE2 - modulator high passes the high carrier
// RULE3 - modulator low passes the low carrier
// RULE4 - enable bit in the control register activates the mixer
// RULE5 - enable clear forces both carriers to constant low
// RULE6 - enable clear forces the modulator to the software data bit
// RULE7 - stored source selections survive disable and apply again on enable
// RULE8 - output disabled while enabled: mixing goes on, pin held low
// RULE9 - clearing pin enable stops driving the pin, module stays on
// RULE10 - four-bit modulator source field with eleven choices
// RULE11 - four-bit high carrier field in the high carrier register
// RULE12 - four-bit low carrier field from the same carrier sources
// RULE13 - synced carrier pulse in progress falls low before switching
// RULE14 - high carrier sync only when its sync bit is set
// RULE15 - low carrier sync only when its own sync bit is set
// RULE16 - serial data source is meaningful only in SPI mode
// RULE17 - modulator code map, codes 1011 and above connect nothing
// RULE18 - each carrier may be inverted by its own polarity bit
// RULE19 - final output may be inverted by an output polarity bit
// RULE20 - any reset disables the mixer and restores register defaults
// RULE21 - carrier codes in listed order, unassigned codes give low
`ifndef SMX_MAP_SVH
`define SMX_MAP_SVH

`define SMX_ADDR_CTRL  4'h0
`define SMX_ADDR_SRC   4'h1
`define SMX_ADDR_HIGH_CARRIER_SIGNAL  4'h2
`define SMX_ADDR_LOW_CARRIER_SIGNAL  4'h3

`define SMX_CTRL_RST   8'h20
`define SMX_SRC_RST    8'h00
`define SMX_CAR_RST    8'h00

`define SMX_CTRL_EN    7
`define SMX_CTRL_OE    6
`define SMX_CTRL_SLR   5
`define SMX_CTRL_OPOL  4
`define SMX_CTRL_OUT   3
`define SMX_CTRL_BIT   0
`define SMX_SRC_ODIS   7
`define SMX_CAR_ODIS   7
`define SMX_CAR_POL    6
`define SMX_CAR_SYNC   5
`define SMX_SEL_MSB    3

`define SMX_PIN_STAGES 3
`define SMX_PIN_COUNT  3

`endif

// File: logic/smx_pkg.sv
// types shared by the signal mixer top and its carrier switch
// assumes smx_map.svh for numeric constants
package smx_pkg;

   typedef enum logic [3:0] {
      SMX_MS_SWBIT = 4'b0000,
      SMX_MS_PIN   = 4'b0001,
      SMX_MS_PWM1  = 4'b0010,
      SMX_MS_PWM2  = 4'b0011,
      SMX_MS_PWM3  = 4'b0100,
      SMX_MS_PWM4  = 4'b0101,
      SMX_MS_CMP1  = 4'b0110,
      SMX_MS_CMP2  = 4'b0111,
      SMX_MS_SPI1  = 4'b1000,
      SMX_MS_SPI2  = 4'b1001,
      SMX_MS_UART  = 4'b1010
   } smx_mod_src_t;

   typedef enum logic [3:0] {
      SMX_CS_PWM1  = 4'b0000,
      SMX_CS_PWM2  = 4'b0001,
      SMX_CS_PWM3  = 4'b0010,
      SMX_CS_PWM4  = 4'b0011,
      SMX_CS_REF   = 4'b0100,
      SMX_CS_PIN1  = 4'b0101,
      SMX_CS_PIN2  = 4'b0110,
      SMX_CS_GND   = 4'b0111
   } smx_car_src_t;

   typedef struct packed {
      logic       odis;
      logic       pol;
      logic       sync;
      logic [3:0] sel;
   } smx_car_cfg_t;

   typedef struct packed {
      logic         en;
      logic         oe;
      logic         slr;
      logic         opol;
      logic         swBit;
      logic         msOdis;
      logic [3:0]   msSel;
      smx_car_cfg_t high_carrier_signal;
      smx_car_cfg_t low_carrier_signal;
      logic [2:0][2:0] pinShift;
      logic [2:0]   pinFlt;
      logic         pinOut;
      logic [7:0]   rdData;
   } smx_top_state_t;

   typedef struct packed {
      logic useHigh;
   } smx_mix_state_t;

endpackage : smx_pkg

// File: logic/smx_mix_if.sv
// carrier and modulator levels between the top and the carrier switch
// assumes both ends on the same clock
interface smx_mix_if;
   logic carHigh;
   logic carLow;
   logic modSig;
   logic syncHigh;
   logic syncLow;
   logic mixed;
   logic useHigh;

   modport mixer (
      input  carHigh,
      input  carLow,
      input  modSig,
      input  syncHigh,
      input  syncLow,
      output mixed,
      output useHigh
   );

   modport feed (
      output carHigh,
      output carLow,
      output modSig,
      output syncHigh,
      output syncLow,
      input  mixed,
      input  useHigh
   );
endinterface : smx_mix_if

// File: logic/smx_mixer.sv
// carrier switch: picks high or low carrier from the modulator level
// assumes carriers and modulator are already on ref_clk
module smx_mixer
   import smx_pkg::*;
(
   input wire logic ref_clk,
   input wire logic srst,
   smx_mix_if.mixer mx
);

   smx_mix_state_t st_q;
   smx_mix_state_t st_d;
   logic           curSync;
   logic           curCar;
   logic           useEff;

   // ------------------------------------------------------------
   // switch decision
   // ------------------------------------------------------------
   // a synced carrier keeps the old side until its pulse falls
   assign curSync = st_q.useHigh ? mx.syncHigh : mx.syncLow; // [RULE14] [RULE15]
   assign curCar  = st_q.useHigh ? mx.carHigh  : mx.carLow;
   assign useEff  = (curSync && curCar) ? st_q.useHigh : mx.modSig; // [RULE13]
   assign mx.mixed   = useEff ? mx.carHigh : mx.carLow; // [RULE1] [RULE2] [RULE3]
   assign mx.useHigh = st_q.useHigh;

   always_comb begin
      st_d = st_q;
      st_d.useHigh = useEff;
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   chk_mix_nosync_hi: assert property ( // [RULE2]
      !mx.syncHigh && !mx.syncLow && mx.modSig |-> mx.mixed == mx.carHigh)
      else $error("high carrier not passed");
   chk_mix_nosync_lo: assert property ( // [RULE3]
      !mx.syncHigh && !mx.syncLow && !mx.modSig |-> mx.mixed == mx.carLow)
      else $error("low carrier not passed");
   chk_sync_hold_high: assert property ( // [RULE14]
      st_q.useHigh && mx.syncHigh && mx.carHigh && !mx.modSig
      |-> mx.mixed ##1 st_q.useHigh)
      else $error("synced high pulse cut short");
   chk_sync_hold_low: assert property ( // [RULE15]
      !st_q.useHigh && mx.syncLow && mx.carLow && mx.modSig
      |-> mx.mixed ##1 !st_q.useHigh)
      else $error("synced low pulse cut short");
   chk_sync_switch_after: assert property ( // [RULE13]
      !curCar |=> st_q.useHigh == $past(mx.modSig))
      else $error("switch not taken once carrier low");

endmodule : smx_mixer

// File: logic/smx_top.sv
// signal mixer: keyed output from a modulator and two carriers
// assumes peripheral sources on ref_clk, pins asynchronous
//
// Our own choices: the register offsets and the plain strobed port.
`include "smx_map.svh"

module smx_top
   import smx_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       srst,
   input  wire logic [3:0] regAddr,
   input  wire logic [7:0] regWrData,
   input  wire logic       regWrEn,
   input  wire logic       regRdEn,
   output logic      [7:0] regRdData,
   input  wire logic [3:0] pwmOut,
   input  wire logic [1:0] cmpOut,
   input  wire logic [1:0] spiSdo,
   input  wire logic       uartTx,
   input  wire logic       refClkSig,
   input  wire logic       externalModulatorPin,
   input  wire logic       externalCarrierPinOne,
   input  wire logic       externalCarrierPinTwo,
   output logic            modulatedOutputPin,
   output logic            slewLimitEn,
   output logic            modSrcPinDisable,
   output logic            highCarPinDisable,
   output logic            lowCarPinDisable
);

   smx_top_state_t st_q;
   smx_top_state_t st_d;
   smx_mix_if      mx ();
   logic [2:0]     pinRaw;
   logic           modSel;
   logic           carHSel;
   logic           carLSel;
   logic           mixPol;
   localparam logic [7:0] ctrlRstVal = `SMX_CTRL_RST;

   // ------------------------------------------------------------
   // source selection
   // ------------------------------------------------------------
   function automatic logic pickCar(
      input logic [3:0] sel,
      input logic [3:0] pwm,
      input logic       refc,
      input logic       p1,
      input logic       p2
   );
      case (sel) // [RULE21]
         SMX_CS_PWM1: pickCar = pwm[0];
         SMX_CS_PWM2: pickCar = pwm[1];
         SMX_CS_PWM3: pickCar = pwm[2];
         SMX_CS_PWM4: pickCar = pwm[3];
         SMX_CS_REF:  pickCar = refc;
         SMX_CS_PIN1: pickCar = p1;
         SMX_CS_PIN2: pickCar = p2;
         SMX_CS_GND:  pickCar = 1'b0;
         default:     pickCar = 1'b0;
      endcase
   endfunction : pickCar

   assign pinRaw = {externalCarrierPinTwo, externalCarrierPinOne,
                    externalModulatorPin};

   // serial data sources are only meaningful while in SPI mode
   always_comb begin
      case (st_q.msSel) // [RULE10] [RULE17] [RULE16]
         SMX_MS_SWBIT: modSel = st_q.swBit;
         SMX_MS_PIN:   modSel = st_q.pinFlt[0];
         SMX_MS_PWM1:  modSel = pwmOut[0];
         SMX_MS_PWM2:  modSel = pwmOut[1];
         SMX_MS_PWM3:  modSel = pwmOut[2];
         SMX_MS_PWM4:  modSel = pwmOut[3];
         SMX_MS_CMP1:  modSel = cmpOut[0];
         SMX_MS_CMP2:  modSel = cmpOut[1];
         SMX_MS_SPI1:  modSel = spiSdo[0];
         SMX_MS_SPI2:  modSel = spiSdo[1];
         SMX_MS_UART:  modSel = uartTx;
         default:      modSel = 1'b0;
      endcase
   end

   assign carHSel = pickCar(st_q.high_carrier_signal.sel, pwmOut, refClkSig, // [RULE11]
                            st_q.pinFlt[1], st_q.pinFlt[2]);
   assign carLSel = pickCar(st_q.low_carrier_signal.sel, pwmOut, refClkSig, // [RULE12]
                            st_q.pinFlt[1], st_q.pinFlt[2]);

   // disabled: carriers to ground, modulator to the software bit,
   // selections stay in the registers untouched
   assign mx.carHigh  = st_q.en & (carHSel ^ st_q.high_carrier_signal.pol); // [RULE5] [RULE18]
   assign mx.carLow   = st_q.en & (carLSel ^ st_q.low_carrier_signal.pol); // [RULE5] [RULE18]
   assign mx.modSig   = st_q.en ? modSel : st_q.swBit; // [RULE4] [RULE6] [RULE7]
   assign mx.syncHigh = st_q.high_carrier_signal.sync;
   assign mx.syncLow  = st_q.low_carrier_signal.sync;
   assign mixPol      = mx.mixed ^ st_q.opol; // [RULE19]

   smx_mixer u_mixer (
      .ref_clk (ref_clk),
      .srst    (srst),
      .mx      (mx)
   );

   // ------------------------------------------------------------
   // state update
   // ------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      // pins cross in three stages; a level is taken once the
      // second and third stage agree, rejecting one-cycle glitches
      for (int i = 0; i < `SMX_PIN_COUNT; i++) begin
         st_d.pinShift[i] = {st_q.pinShift[i][1:0], pinRaw[i]};
         if (st_q.pinShift[i][1] == st_q.pinShift[i][2]) begin
            st_d.pinFlt[i] = st_q.pinShift[i][2];
         end
      end
      if (regWrEn) begin
         case (regAddr)
            `SMX_ADDR_CTRL: begin
               st_d.en    = regWrData[`SMX_CTRL_EN]; // [RULE4]
               st_d.oe    = regWrData[`SMX_CTRL_OE]; // [RULE9]
               st_d.slr   = regWrData[`SMX_CTRL_SLR];
               st_d.opol  = regWrData[`SMX_CTRL_OPOL];
               st_d.swBit = regWrData[`SMX_CTRL_BIT];
            end
            `SMX_ADDR_SRC: begin
               st_d.msOdis = regWrData[`SMX_SRC_ODIS];
               st_d.msSel  = regWrData[`SMX_SEL_MSB:0];
            end
            `SMX_ADDR_HIGH_CARRIER_SIGNAL: begin
               st_d.high_carrier_signal.odis = regWrData[`SMX_CAR_ODIS];
               st_d.high_carrier_signal.pol  = regWrData[`SMX_CAR_POL];
               st_d.high_carrier_signal.sync = regWrData[`SMX_CAR_SYNC]; // [RULE14]
               st_d.high_carrier_signal.sel  = regWrData[`SMX_SEL_MSB:0];
            end
            `SMX_ADDR_LOW_CARRIER_SIGNAL: begin
               st_d.low_carrier_signal.odis = regWrData[`SMX_CAR_ODIS];
               st_d.low_carrier_signal.pol  = regWrData[`SMX_CAR_POL];
               st_d.low_carrier_signal.sync = regWrData[`SMX_CAR_SYNC]; // [RULE15]
               st_d.low_carrier_signal.sel  = regWrData[`SMX_SEL_MSB:0];
            end
            default: begin
            end
         endcase
      end
      st_d.rdData = 8'h00;
      if (regRdEn) begin
         case (regAddr)
            `SMX_ADDR_CTRL: begin
               st_d.rdData[`SMX_CTRL_EN]   = st_q.en;
               st_d.rdData[`SMX_CTRL_OE]   = st_q.oe;
               st_d.rdData[`SMX_CTRL_SLR]  = st_q.slr;
               st_d.rdData[`SMX_CTRL_OPOL] = st_q.opol;
               st_d.rdData[`SMX_CTRL_OUT]  = st_q.pinOut;
               st_d.rdData[`SMX_CTRL_BIT]  = st_q.swBit;
            end
            `SMX_ADDR_SRC: begin
               st_d.rdData[`SMX_SRC_ODIS]   = st_q.msOdis;
               st_d.rdData[`SMX_SEL_MSB:0]  = st_q.msSel;
            end
            `SMX_ADDR_HIGH_CARRIER_SIGNAL: begin
               st_d.rdData[`SMX_CAR_ODIS]  = st_q.high_carrier_signal.odis;
               st_d.rdData[`SMX_CAR_POL]   = st_q.high_carrier_signal.pol;
               st_d.rdData[`SMX_CAR_SYNC]  = st_q.high_carrier_signal.sync;
               st_d.rdData[`SMX_SEL_MSB:0] = st_q.high_carrier_signal.sel;
            end
            `SMX_ADDR_LOW_CARRIER_SIGNAL: begin
               st_d.rdData[`SMX_CAR_ODIS]  = st_q.low_carrier_signal.odis;
               st_d.rdData[`SMX_CAR_POL]   = st_q.low_carrier_signal.pol;
               st_d.rdData[`SMX_CAR_SYNC]  = st_q.low_carrier_signal.sync;
               st_d.rdData[`SMX_SEL_MSB:0] = st_q.low_carrier_signal.sel;
            end
            default: begin
            end
         endcase
      end
      // pin held low while not driven; mixing itself goes on
      st_d.pinOut = (st_q.en && st_q.oe) ? mixPol : 1'b0; // [RULE8] [RULE9]
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin // [RULE20]
         st_q          <= '0;
         st_q.en       <= ctrlRstVal[`SMX_CTRL_EN];
         st_q.slr      <= ctrlRstVal[`SMX_CTRL_SLR];
      end else begin
         st_q <= st_d;
      end
   end

   assign regRdData          = st_q.rdData;
   assign modulatedOutputPin = st_q.pinOut;
   assign slewLimitEn        = st_q.slr;
   assign modSrcPinDisable   = st_q.msOdis;
   assign highCarPinDisable  = st_q.high_carrier_signal.odis;
   assign lowCarPinDisable   = st_q.low_carrier_signal.odis;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   chk_reset_defaults: assert property ( // [RULE20]
      disable iff (1'b0) srst |=> !st_q.en && st_q.slr && !st_q.oe
      && !modulatedOutputPin)
      else $error("reset did not restore defaults");
   chk_off_carriers_low: assert property ( // [RULE5]
      !st_q.en |-> !mx.carHigh && !mx.carLow ##1 !modulatedOutputPin)
      else $error("carriers live while disabled");
   chk_off_mod_swbit: assert property ( // [RULE6]
      !st_q.en |-> mx.modSig == st_q.swBit)
      else $error("modulator not on software bit");
   chk_sel_kept: assert property ( // [RULE7]
      !regWrEn |=> $stable(st_q.msSel) && $stable(st_q.high_carrier_signal.sel)
      && $stable(st_q.low_carrier_signal.sel))
      else $error("selection changed without a write");
   chk_pin_off_low: assert property ( // [RULE8]
      st_q.en && !st_q.oe |=> !modulatedOutputPin)
      else $error("pin driven while output disabled");
   chk_pin_follows: assert property ( // [RULE19]
      st_q.en && st_q.oe |=> modulatedOutputPin == $past(mixPol))
      else $error("pin does not follow mixed output");
   chk_mod_code_none: assert property ( // [RULE17]
      st_q.en && st_q.msSel > 4'ha |-> !mx.modSig)
      else $error("reserved modulator code not low");
   chk_car_unassigned: assert property ( // [RULE21]
      st_q.en && st_q.high_carrier_signal.sel > 4'h6 |-> mx.carHigh == st_q.high_carrier_signal.pol)
      else $error("unassigned carrier not low");
   chk_enable_write: assert property ( // [RULE4]
      regWrEn && regAddr == `SMX_ADDR_CTRL
      |=> st_q.en == $past(regWrData[`SMX_CTRL_EN]))
      else $error("enable write not taken");
   chk_read_status: assert property ( // [RULE9]
      regRdEn && regAddr == `SMX_ADDR_CTRL
      |=> regRdData[`SMX_CTRL_OUT] == $past(modulatedOutputPin))
      else $error("status bit mismatch");

   // ------------------------------------------------------------
   // source selection checks
   // ------------------------------------------------------------
   chk_src_swbit: assert property ( // [RULE17]
      st_q.en && st_q.msSel == 4'h0 |-> mx.modSig == st_q.swBit)
      else $error("software bit not routed");

   chk_src_pin: assert property ( // [RULE17]
      st_q.en && st_q.msSel == 4'h1 |-> mx.modSig == st_q.pinFlt[0])
      else $error("modulator pin not routed");

   chk_src_uart: assert property ( // [RULE10]
      st_q.en && st_q.msSel == 4'ha |-> mx.modSig == uartTx)
      else $error("uart line not routed");

   chk_car_high_pwm: assert property ( // [RULE18]
      st_q.en && st_q.high_carrier_signal.sel == 4'h0
      |-> mx.carHigh == (pwmOut[0] ^ st_q.high_carrier_signal.pol))
      else $error("high carrier pwm or invert wrong");

   chk_car_high_ref: assert property ( // [RULE11]
      st_q.en && st_q.high_carrier_signal.sel == 4'h4
      |-> mx.carHigh == (refClkSig ^ st_q.high_carrier_signal.pol))
      else $error("reference clock not routed");

   chk_car_low_pin: assert property ( // [RULE12]
      st_q.en && st_q.low_carrier_signal.sel == 4'h6
      |-> mx.carLow == (st_q.pinFlt[2] ^ st_q.low_carrier_signal.pol))
      else $error("second carrier pin not routed");

   chk_car_low_none: assert property ( // [RULE21]
      st_q.en && st_q.low_carrier_signal.sel > 4'h6 |-> mx.carLow == st_q.low_carrier_signal.pol)
      else $error("unassigned low carrier not low");

   // filtered level holds while the last two stages disagree
   chk_pin_glitch: assert property ( // [RULE17]
      st_q.pinShift[0][1] != st_q.pinShift[0][2]
      |=> $stable(st_q.pinFlt[0]))
      else $error("pin filter let a glitch through");

   // ------------------------------------------------------------
   // output checks
   // ------------------------------------------------------------
   chk_reenable_src: assert property ( // [RULE7]
      $rose(st_q.en) |-> mx.modSig == modSel)
      else $error("stored source not reapplied");

   // a synced carrier may hold the old side, so keying is only
   // checked here with both sync bits off
   chk_key_output: assert property ( // [RULE1]
      st_q.en && st_q.oe && !st_q.opol
      && !st_q.high_carrier_signal.sync && !st_q.low_carrier_signal.sync
      |=> modulatedOutputPin == $past(mx.modSig ? mx.carHigh : mx.carLow))
      else $error("output is not the keyed carrier");

   chk_pin_invert: assert property ( // [RULE19]
      st_q.en && st_q.oe && st_q.opol
      |=> modulatedOutputPin == !$past(mx.mixed))
      else $error("output invert not applied");

   chk_oe_write: assert property ( // [RULE9]
      regWrEn && regAddr == `SMX_ADDR_CTRL
      |=> st_q.oe == $past(regWrData[`SMX_CTRL_OE]))
      else $error("output enable write not taken");

   cov_enable_mix: cover property (st_q.en && st_q.oe && mx.mixed);
   cov_sync_hold: cover property (
      st_q.high_carrier_signal.sync && mx.useHigh && mx.carHigh && !mx.modSig);
   cov_reenable: cover property ($fell(st_q.en) ##[1:20] $rose(st_q.en));
   cov_invert_out: cover property (st_q.opol && modulatedOutputPin);
   cov_oe_off_mix: cover property (st_q.en && !st_q.oe && mx.mixed);

endmodule : smx_top

// File: verif/smx_src_model.sv
// source model: peripheral outputs and external pins feeding the mixer
// assumes the bench sets levels just after a rising edge of ref_clk
module smx_src_model (
   input  wire logic        ref_clk,
   input  wire logic [12:0] srcLevel,
   input  wire logic        spiMode,
   output logic      [3:0]  pwmOut    = 4'h0,
   output logic      [1:0]  cmpOut    = 2'h0,
   output logic      [1:0]  spiSdo    = 2'h0,
   output logic             uartTx    = 1'b0,
   output logic             refClkSig = 1'b0,
   output logic             modPin    = 1'b0,
   output logic             carPin1   = 1'b0,
   output logic             carPin2   = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------
   // registered source levels
   // ----------------------------------------
   always @(posedge ref_clk) begin
      pwmOut    <= srcLevel[3:0];
      cmpOut    <= srcLevel[5:4];
      // serial data has no meaning outside spi mode, so it idles low
      spiSdo    <= spiMode ? srcLevel[7:6] : 2'h0;
      uartTx    <= srcLevel[8];
      refClkSig <= srcLevel[9];
      modPin    <= srcLevel[10];
      carPin1   <= srcLevel[11];
      carPin2   <= srcLevel[12];
   end
endmodule : smx_src_model

// File: verif/data_signal_modulator_bench.sv
// self-checking bench for the signal mixer top
// assumes smx_top and smx_src_model compiled first, single clock
`include "smx_map.svh"
module data_signal_modulator_bench;
   timeunit 1ns;
   timeprecision 1ps;

   logic        ref_clk   = 1'b0;
   logic        srst      = 1'b1;
   logic [3:0]  regAddr   = 4'h0;
   logic [7:0]  regWrData = 8'h00;
   logic        regWrEn   = 1'b0;
   logic        regRdEn   = 1'b0;
   logic [12:0] srcLevel  = 13'h0000;
   logic        spiMode   = 1'b1;
   logic [7:0]  regRdData;
   logic [3:0]  pwmOut;
   logic [1:0]  cmpOut;
   logic [1:0]  spiSdo;
   logic        uartTx;
   logic        refClkSig;
   logic        modPin;
   logic        carPin1;
   logic        carPin2;
   logic        outPin;
   logic        slewEn;
   logic        srcDis;
   logic        highDis;
   logic        lowDis;
   logic [7:0]  rd;
   int          fail_count  = 0;
   int          comparisons = 0;

   always #2 ref_clk = ~ref_clk;

   smx_src_model u_src (.ref_clk(ref_clk), .srcLevel(srcLevel),
      .spiMode(spiMode), .pwmOut(pwmOut), .cmpOut(cmpOut),
      .spiSdo(spiSdo), .uartTx(uartTx), .refClkSig(refClkSig),
      .modPin(modPin), .carPin1(carPin1), .carPin2(carPin2));

   smx_top u_dut (.ref_clk(ref_clk), .srst(srst), .regAddr(regAddr),
      .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
      .regRdData(regRdData), .pwmOut(pwmOut), .cmpOut(cmpOut),
      .spiSdo(spiSdo), .uartTx(uartTx), .refClkSig(refClkSig),
      .externalModulatorPin(modPin), .externalCarrierPinOne(carPin1),
      .externalCarrierPinTwo(carPin2), .modulatedOutputPin(outPin),
      .slewLimitEn(slewEn), .modSrcPinDisable(srcDis),
      .highCarPinDisable(highDis), .lowCarPinDisable(lowDis));

   // ----------------------------------------
   // access and compare tasks
   // ----------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t ns: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic regWrite(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      regAddr   <= a;
      regWrData <= d;
      regWrEn   <= 1'b1;
      @(posedge ref_clk);
      regWrEn   <= 1'b0;
   endtask : regWrite

   task automatic regRead(input logic [3:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge ref_clk);
      regRdEn <= 1'b0;
      #1 d = regRdData;
   endtask : regRead

   // pins need the synchroniser and filter, so allow a few extra cycles
   task automatic settle;
      repeat (8) @(posedge ref_clk);
      #1;
   endtask : settle

   task automatic setLevel(input logic [12:0] v);
      @(posedge ref_clk);
      srcLevel <= v;
   endtask : setLevel

   // source position in srcLevel, 13 = software bit, -1 = nothing
   function automatic int srcIdx(input bit car, input logic [3:0] c);
      if (car)
         return (c < 4) ? int'(c) : (c == 4) ? 9 : (c == 5) ? 11 :
                (c == 6) ? 12 : -1;
      return (c == 0) ? 13 : (c == 1) ? 10 : (c <= 10) ? int'(c) - 2 : -1;
   endfunction : srcIdx

   // kind 0 modulator, 1 high carrier, 2 low carrier; others constant
   task automatic route(input int kind, input logic [3:0] code);
      int          idx;
      logic [13:0] lv;
      idx = srcIdx(kind != 0, code);
      for (int hit = 0; hit < 2; hit++) begin
         lv = (idx < 0) ? 14'h3fff :
              hit ? (14'h0001 << idx) : ~(14'h0001 << idx);
         setLevel(lv[12:0]);
         regWrite(`SMX_ADDR_SRC, (kind == 0) ? {4'h0, code} : 8'h00);
         regWrite(`SMX_ADDR_HIGH_CARRIER_SIGNAL, (kind == 1) ? {4'h0, code} : 8'h47);
         regWrite(`SMX_ADDR_LOW_CARRIER_SIGNAL, (kind == 2) ? {4'h0, code} : 8'h07);
         regWrite(`SMX_ADDR_CTRL, {7'h60, (kind == 1) ? 1'b1 :
                                   (kind == 0) ? lv[13] : 1'b0});
         settle;
         check({7'h00, outPin}, {7'h00, idx >= 0 && hit == 1});
      end
   endtask : route

   task automatic syncCase(input logic [7:0] high_carrier_signal, input logic [7:0] low_carrier_signal,
                           input logic startBit, input logic hold);
      setLevel(13'h0001);
      regWrite(`SMX_ADDR_SRC, 8'h00);
      regWrite(`SMX_ADDR_CTRL, {7'h60, startBit});
      regWrite(`SMX_ADDR_HIGH_CARRIER_SIGNAL, high_carrier_signal);
      regWrite(`SMX_ADDR_LOW_CARRIER_SIGNAL, low_carrier_signal);
      settle;
      check({7'h00, outPin}, 8'h01);
      regWrite(`SMX_ADDR_CTRL, {7'h60, ~startBit});
      settle;
      check({7'h00, outPin}, {7'h00, hold});
      setLevel(13'h0000);
      settle;
      check({7'h00, outPin}, 8'h00);
      setLevel(13'h0001);
      settle;
      check({7'h00, outPin}, 8'h00);
   endtask : syncCase

   task automatic final_report;
      $display("checks %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : final_report

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (12) @(posedge ref_clk);
      srst <= 1'b0;
      @(posedge ref_clk);
      #1;
      check({6'h00, slewEn, outPin}, 8'h02);
      for (int a = 0; a < 4; a++) begin
         regRead(a[3:0], rd);
         check(rd, (a == 0) ? 8'h20 : 8'h00);
      end
      regWrite(4'h9, 8'hff);
      regRead(4'h9, rd);
      check(rd, 8'h00);
      for (int a = 1; a < 4; a++) begin
         regWrite(a[3:0], 8'hff);
         regRead(a[3:0], rd);
         check(rd, (a == 1) ? 8'h8f : 8'hef);
      end
      check({5'h00, srcDis, highDis, lowDis}, 8'h07);
      for (int c = 0; c < 16; c++) begin
         route(0, c[3:0]);
         route(1, c[3:0]);
         route(2, c[3:0]);
      end
      // disable, re-enable, output gating and invert
      regWrite(`SMX_ADDR_SRC, 8'h0a);
      regWrite(`SMX_ADDR_HIGH_CARRIER_SIGNAL, 8'h47);
      setLevel(13'h0100);
      regWrite(`SMX_ADDR_CTRL, 8'hc7);
      settle;
      check({7'h00, outPin}, 8'h01);
      regRead(`SMX_ADDR_CTRL, rd);
      check(rd, 8'hc9);
      regWrite(`SMX_ADDR_CTRL, 8'h51);
      settle;
      check({7'h00, outPin}, 8'h00);
      regRead(`SMX_ADDR_SRC, rd);
      check(rd, 8'h0a);
      regRead(`SMX_ADDR_HIGH_CARRIER_SIGNAL, rd);
      check(rd, 8'h47);
      regWrite(`SMX_ADDR_CTRL, 8'hc1);
      settle;
      check({7'h00, outPin}, 8'h01);
      regWrite(`SMX_ADDR_CTRL, 8'h81);
      settle;
      check({7'h00, outPin}, 8'h00);
      regRead(`SMX_ADDR_CTRL, rd);
      check(rd, 8'h81);
      regWrite(`SMX_ADDR_CTRL, 8'hd1);
      settle;
      check({7'h00, outPin}, 8'h00);
      syncCase(8'h20, 8'h07, 1'b1, 1'b1);
      syncCase(8'h00, 8'h07, 1'b1, 1'b0);
      syncCase(8'h07, 8'h20, 1'b0, 1'b1);
      syncCase(8'h07, 8'h00, 1'b0, 1'b0);
      // second reset in mid-run
      @(posedge ref_clk);
      srst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      srst <= 1'b0;
      regRead(`SMX_ADDR_CTRL, rd);
      check(rd, 8'h20);
      check({7'h00, outPin}, 8'h00);
      final_report;
   end

   initial begin
      #60000;
      fail_count++;
      final_report;
   end
endmodule : data_signal_modulator_bench
